/* File: verilog/reset_stop_recovery.sv */
// reset pin, short reset and stop mode recovery sequencer
`timescale 1ns/1ps
`default_nettype none
`include "stop_recovery_cfg.svh"

// What this block does
// - A low reset pin starts the short reset sequence.
// - While the reset pin stays low the core stays held in reset.
// - If the pin is held past the short reset time-out, reset ends right after the pin rises.
// - A short reset from the pin sets the external reset flag.
// - Stop mode is entered only on the CPU's stop instruction.
// - Stop recovery holds the core for 514 watchdog oscillator cycles then 16 system clocks.
// - Stop recovery leaves the register file, pointers, flags and RAM untouched.
// - After recovery the vector is read from 0002H and 0003H into the program counter.
// - Every stop recovery sets the stop recovery flag.
// - A watchdog time-out in stop starts recovery and sets the watchdog and stop flags.
// - A watchdog set for reset only causes recovery, with no interrupt.
// - A watchdog set for interrupt, with interrupts on, is serviced after recovery ends.
// - A transition on any enabled stop recovery port pin starts recovery.
module reset_stop_recovery
  import stop_recovery_pkg::*;
#(
  parameter logic [15:0] SHORT_RESET_CYCLES = `SHORT_RESET_CYCLES
)(
  // clock and system reset
  input wire logic mclk,
  input wire logic nrst,
  // external reset pin, active low
  input wire logic reset_pin_n,
  // cpu side
  input wire logic stop_exec,
  input wire logic irq_enable,
  output logic core_reset,
  output logic regfile_reset,
  output logic in_stop,
  // reset vector fetch
  output logic vec_rd,
  output logic [15:0] vec_addr,
  input wire logic [7:0] vec_data,
  output logic pc_load,
  output logic [15:0] pc,
  // watchdog
  input wire logic wdt_osc_tick,
  input wire logic wdt_timeout,
  input wire logic wdt_int_mode,
  output logic wdt_irq_req,
  // stop recovery port pins
  input wire logic [`SMR_PIN_COUNT-1:0] port_pins,
  input wire logic [`SMR_PIN_COUNT-1:0] port_smr_en,
  // watchdog control register status bits and their clears
  output logic [2:0] watchdog_control_reg,
  output logic external_reset_flag,
  output logic watchdog_timeout_flag,
  output logic stop_recovery_flag,
  input wire logic clear_external_reset_flag,
  input wire logic clear_watchdog_timeout_flag,
  input wire logic clear_stop_recovery_flag
);

  seq_regs_t r;
  seq_regs_t next_r;
  logic wdt_stop_event;
  logic pin_event;
  logic smr_trigger;
  logic set_ext;
  logic set_wdt;
  logic set_stop;

  port_watch_if pw ();

  // port pin transition watcher
  port_transition_watch u_watch (
    .mclk(mclk),
    .nrst(nrst),
    .pw(pw.watch)
  );

  // feed the watcher, armed only while stopped
  assign pw.pins = port_pins;
  assign pw.enables = port_smr_en;
  assign pw.armed = (r.st == st_stop);

  // recovery sources while stopped
  always_comb begin
    wdt_stop_event = (r.st == st_stop) & wdt_timeout;
    pin_event = pw.hit;
    smr_trigger = wdt_stop_event | pin_event;
  end

  // next state of the sequencer
  always_comb begin
    next_r = r;
    set_ext = 1'b0;
    set_wdt = 1'b0;
    set_stop = 1'b0;
    next_r.pc_load = 1'b0;
    next_r.irq_req = 1'b0;
    // two flop synchroniser for the pin
    next_r.pin_meta = reset_pin_n;
    next_r.pin_sync = r.pin_meta;
    if (!r.pin_sync && r.st != st_short) begin
      // pin low from any state other than the short reset restarts it
      next_r.st = st_short;
      next_r.cnt = `CNT_RESET;
      // a pending watchdog interrupt dies with the pin reset
      next_r.irq_pend = 1'b0;
    end else begin
      unique case (r.st)
        st_short: begin
          // count the time-out, then wait for the pin to rise
          if (r.cnt < SHORT_RESET_CYCLES) begin
            next_r.cnt = r.cnt + 16'h0001;
          end else if (r.pin_sync) begin
            next_r.st = st_vec_hi;
            next_r.cnt = `CNT_RESET;
            next_r.vec_addr = `VEC_HI_ADDR;
            set_ext = 1'b1;
          end
        end
        st_vec_hi: begin
          next_r.pc[15:8] = vec_data;
          next_r.vec_addr = `VEC_LO_ADDR;
          next_r.st = st_vec_lo;
        end
        st_vec_lo: begin
          next_r.pc[7:0] = vec_data;
          next_r.pc_load = 1'b1;
          next_r.st = st_run;
        end
        st_run: begin
          // deferred watchdog interrupt once recovery is over
          if (r.irq_pend) begin
            next_r.irq_req = irq_enable;
            next_r.irq_pend = 1'b0;
          end
          if (stop_exec) begin
            next_r.st = st_stop;
          end
        end
        st_stop: begin
          if (smr_trigger) begin
            next_r.st = st_smr_osc;
            next_r.cnt = `CNT_RESET;
            set_wdt = wdt_stop_event;
            // interrupt only when the watchdog is set for it
            next_r.irq_pend = wdt_stop_event & wdt_int_mode;
          end
        end
        st_smr_osc: begin
          // count watchdog oscillator cycles
          if (wdt_osc_tick) begin
            if (r.cnt == `SMR_OSC_CYCLES - 16'h0001) begin
              next_r.st = st_smr_sys;
              next_r.cnt = `CNT_RESET;
            end else begin
              next_r.cnt = r.cnt + 16'h0001;
            end
          end
        end
        st_smr_sys: begin
          // then count system clocks
          if (r.cnt == `SMR_SYS_CYCLES - 16'h0001) begin
            next_r.st = st_vec_hi;
            next_r.cnt = `CNT_RESET;
            next_r.vec_addr = `VEC_HI_ADDR;
            set_stop = 1'b1;
          end else begin
            next_r.cnt = r.cnt + 16'h0001;
          end
        end
        default: begin
          next_r.st = st_short;
          next_r.cnt = `CNT_RESET;
        end
      endcase
    end
    // status flags: a set in the same cycle as a clear wins
    next_r.external_reset_flag =
      set_ext | (r.external_reset_flag & ~clear_external_reset_flag);
    next_r.watchdog_timeout_flag =
      set_wdt | (r.watchdog_timeout_flag & ~clear_watchdog_timeout_flag);
    next_r.stop_recovery_flag =
      set_stop | (r.stop_recovery_flag & ~clear_stop_recovery_flag);
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r <= '0;
      r.st <= st_short;
      r.pc <= `PC_RESET;
      r.cnt <= `CNT_RESET;
    end else begin
      r <= next_r;
    end
  end

  // core held in reset until the vector is loaded
  assign core_reset = (r.st != st_run) & (r.st != st_stop);
  // only the short reset clears the register file
  assign regfile_reset = (r.st == st_short);
  assign in_stop = (r.st == st_stop);
  assign vec_rd = (r.st == st_vec_hi) | (r.st == st_vec_lo);
  assign vec_addr = r.vec_addr;
  assign pc = r.pc;
  assign pc_load = r.pc_load;
  assign wdt_irq_req = r.irq_req;

  // status bits as seen by software
  assign external_reset_flag = r.external_reset_flag;
  assign watchdog_timeout_flag = r.watchdog_timeout_flag;
  assign stop_recovery_flag = r.stop_recovery_flag;
  assign watchdog_control_reg = {r.stop_recovery_flag, r.watchdog_timeout_flag,
                                 r.external_reset_flag};

endmodule

`default_nettype wire

/* File: verilog/stop_recovery_cfg.svh */
// constants for the reset and stop recovery sequencer
`ifndef STOP_RECOVERY_CFG_SVH
`define STOP_RECOVERY_CFG_SVH

// short reset length in system clocks (default only, see top parameter)
`define SHORT_RESET_CYCLES 16'd64
// stop recovery hold: watchdog oscillator cycles, then system clocks
`define SMR_OSC_CYCLES 16'd514
`define SMR_SYS_CYCLES 16'd16
// reset vector location in program memory
`define VEC_HI_ADDR 16'h0002
`define VEC_LO_ADDR 16'h0003
// port pins watched as stop recovery sources
`define SMR_PIN_COUNT 8
// reset values
`define PC_RESET 16'h0000
`define CNT_RESET 16'h0000

`endif

/* File: verilog/stop_recovery_pkg.sv */
// types for the reset and stop recovery sequencer
`include "stop_recovery_cfg.svh"

package stop_recovery_pkg;

  // gray coded along short -> vector -> run -> stop -> recovery -> vector
  typedef enum logic [2:0] {
    st_short = 3'b000,
    st_vec_hi = 3'b001,
    st_vec_lo = 3'b011,
    st_run = 3'b010,
    st_stop = 3'b110,
    st_smr_osc = 3'b111,
    st_smr_sys = 3'b101
  } seq_state_t;

  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    seq_state_t st;
    logic [15:0] cnt;
    logic [15:0] pc;
    logic [15:0] vec_addr;
    logic pc_load;
    logic external_reset_flag;
    logic watchdog_timeout_flag;
    logic stop_recovery_flag;
    logic irq_pend;
    logic irq_req;
  } seq_regs_t;

  typedef struct packed {
    logic [`SMR_PIN_COUNT-1:0] prev;
    logic hit;
  } watch_regs_t;

endpackage

/* File: verilog/port_watch_if.sv */
// carrier between the sequencer and its port transition watcher
`timescale 1ns/1ps
`default_nettype none
`include "stop_recovery_cfg.svh"

interface port_watch_if;
  import stop_recovery_pkg::*;
  logic [`SMR_PIN_COUNT-1:0] pins;
  logic [`SMR_PIN_COUNT-1:0] enables;
  logic armed;
  logic hit;
  modport seq (output pins, output enables, output armed, input hit);
  modport watch (input pins, input enables, input armed, output hit);
endinterface

`default_nettype wire

/* File: verilog/port_transition_watch.sv */
// detects a data transition on any enabled stop recovery port pin
`timescale 1ns/1ps
`default_nettype none
`include "stop_recovery_cfg.svh"

module port_transition_watch
  import stop_recovery_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // link to the sequencer
  port_watch_if.watch pw
);

  watch_regs_t r;
  watch_regs_t next_r;
  logic [`SMR_PIN_COUNT-1:0] changed;

  // per pin change detect, gated by its enable
  genvar i;
  generate
    for (i = 0; i < `SMR_PIN_COUNT; i++) begin : g_pin
      assign changed[i] = pw.enables[i] & (pw.pins[i] ^ r.prev[i]);
    end
  endgenerate

  // track pins always, report only while armed
  always_comb begin
    next_r = r;
    next_r.prev = pw.pins;
    next_r.hit = pw.armed & (|changed);
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pw.hit = r.hit;

endmodule

`default_nettype wire

/* File: tb/reset_stop_recovery_assertions.sv */
// port checks for the reset and stop recovery sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_stop_recovery_assertions #(
  parameter logic [15:0] SHORT_RESET_CYCLES = 16'h0004
) (
  // clock, reset and pins
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic stop_exec,
  input wire logic irq_enable,
  input wire logic wdt_timeout,
  // sequencer outputs, plus the vector data it reads
  input wire logic core_reset,
  input wire logic regfile_reset,
  input wire logic in_stop,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  input wire logic [7:0] vec_data,
  input wire logic pc_load,
  input wire logic [15:0] pc,
  input wire logic wdt_irq_req,
  input wire logic external_reset_flag,
  input wire logic watchdog_timeout_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // second vector byte then first run cycle
  sequence fetch_tail;
    vec_rd && vec_addr == 16'h0003 ##1 pc_load && !core_reset;
  endsequence
  chk_vector_order: assert property (vec_rd && vec_addr == 16'h0002 |=> fetch_tail)
    else $error("vector fetch out of order");
  chk_pc_bytes: assert property (pc_load |-> pc == {$past(vec_data, 2), $past(vec_data)})
    else $error("pc not built from vector bytes");
  chk_pin_starts: assert property ($fell(reset_pin_n) |-> ##3 regfile_reset)
    else $error("pin low did not start short reset");
  chk_pin_holds: assert property (!reset_pin_n [*3] |=> core_reset)
    else $error("core released with pin low");
  chk_stop_cause: assert property ($rose(in_stop) |-> $past(stop_exec && !core_reset))
    else $error("stop entered without instruction");
  chk_stop_entry: assert property (
    stop_exec && !core_reset && !in_stop && $past(reset_pin_n, 2) |=> in_stop)
    else $error("stop instruction ignored");
  chk_wdt_wakes: assert property (in_stop && wdt_timeout && $past(reset_pin_n, 2)
    |=> !in_stop && core_reset && watchdog_timeout_flag)
    else $error("watchdog time-out did not wake");
  chk_regfile_kept: assert property ($fell(in_stop) && !regfile_reset |-> !regfile_reset [*8])
    else $error("register file cleared in recovery");
  chk_irq_after: assert property (
    $rose(wdt_irq_req) |-> $past(pc_load) && $past(irq_enable))
    else $error("watchdog irq out of place");
  chk_ext_flag: assert property ($rose(external_reset_flag) |-> vec_rd)
    else $error("external flag set outside fetch");
endmodule
`default_nettype wire

/* File: tb/vec_mem_osc_model.sv */
// program memory vector bytes and watchdog oscillator model
`timescale 1ns/1ps
`default_nettype none
module vec_mem_osc_model #(
  parameter logic [7:0] VEC_HI = 8'h12,
  parameter logic [7:0] VEC_LO = 8'h34,
  parameter int DIV = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // memory and oscillator
  input wire logic [15:0] vec_addr,
  output logic [7:0] vec_data,
  output logic wdt_osc_tick
);
  int div_cnt;
  // vector bytes; elsewhere the inverted low address byte
  assign vec_data = (vec_addr == 16'h0002) ? VEC_HI :
                    (vec_addr == 16'h0003) ? VEC_LO : ~vec_addr[7:0];
  // free running oscillator, one tick every DIV clocks
  always @(posedge mclk) begin
    if (!nrst || div_cnt == DIV - 1)
      div_cnt <= 0;
    else
      div_cnt <= div_cnt + 1;
  end
  assign wdt_osc_tick = (div_cnt == DIV - 1);
endmodule
`default_nettype wire

/* File: tb/reset_stop_recovery_tb.sv */
// self-checking bench for the reset and stop recovery sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_stop_recovery_tb;
  import stop_recovery_pkg::*;
  localparam int DIV = 2;
  logic mclk, nrst, reset_pin_n, stop_exec, irq_enable, wdt_timeout, wdt_int_mode;
  logic core_reset, regfile_reset, in_stop, vec_rd, pc_load, wdt_osc_tick, wdt_irq_req;
  logic ext_f, wdt_f, stop_f;
  logic [15:0] vec_addr, pc;
  logic [7:0] vec_data, port_pins, port_smr_en;
  logic [2:0] watchdog_control_reg, clr;
  int failures, checked, irq_seen, cycles, n;
  reset_stop_recovery #(.SHORT_RESET_CYCLES(16'h0004)) i_dut (.mclk(mclk), .nrst(nrst),
    .reset_pin_n(reset_pin_n), .stop_exec(stop_exec), .irq_enable(irq_enable),
    .core_reset(core_reset), .regfile_reset(regfile_reset), .in_stop(in_stop), .vec_rd(vec_rd),
    .vec_addr(vec_addr), .vec_data(vec_data), .pc_load(pc_load), .pc(pc),
    .wdt_osc_tick(wdt_osc_tick), .wdt_timeout(wdt_timeout), .wdt_int_mode(wdt_int_mode),
    .wdt_irq_req(wdt_irq_req), .port_pins(port_pins), .port_smr_en(port_smr_en),
    .watchdog_control_reg(watchdog_control_reg), .external_reset_flag(ext_f),
    .watchdog_timeout_flag(wdt_f), .stop_recovery_flag(stop_f),
    .clear_external_reset_flag(clr[0]), .clear_watchdog_timeout_flag(clr[1]),
    .clear_stop_recovery_flag(clr[2]));
  vec_mem_osc_model #(.DIV(DIV)) i_mem (.mclk(mclk), .nrst(nrst), .vec_addr(vec_addr),
    .vec_data(vec_data), .wdt_osc_tick(wdt_osc_tick));
  // clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // irq pulses and hang guard
  always @(posedge mclk) begin
    cycles++;
    if (wdt_irq_req === 1'b1)
      irq_seen++;
    if (cycles == 8000) begin
      failures++;
      conclude();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // count cycles until the first run cycle
  task wait_run;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (pc_load !== 1'b1 && n < 3000);
  endtask
  // stop, wake by watchdog or enabled pin, then judge timing and flags
  task wake(input logic by_wdt, input logic im, input logic ie, input int exp_irq);
    clr = 3'h7;
    tick(1);
    clr = 3'h0;
    stop_exec = 1'b1;
    tick(1);
    stop_exec = 1'b0;
    tick(1);
    check(in_stop, 1);
    wdt_int_mode = im;
    irq_enable = ie;
    if (by_wdt) begin
      wdt_timeout = 1'b1;
    end else begin
      port_pins[7] = ~port_pins[7];
      tick(5);
      check(in_stop, 1);
      port_pins[0] = ~port_pins[0];
    end
    tick(1);
    wdt_timeout = 1'b0;
    irq_seen = 0;
    wait_run();
    tick(3);
    check(n >= 514 * DIV + 16 && n <= 514 * DIV + 30, 1);
    check(16'(irq_seen), 16'(exp_irq));
    check(watchdog_control_reg, {1'b1, by_wdt, 1'b0});
    check({stop_f, wdt_f, ext_f}, {1'b1, by_wdt, 1'b0});
  endtask
  // main sequence
  initial begin
    nrst = 0;
    reset_pin_n = 1;
    stop_exec = 0;
    irq_enable = 0;
    wdt_timeout = 0;
    wdt_int_mode = 0;
    port_pins = 8'h00;
    port_smr_en = 8'h01;
    clr = 3'h0;
    failures = 0;
    checked = 0;
    irq_seen = 0;
    cycles = 0;
    tick(10);
    nrst = 1;
    wait_run();
    check(pc, 16'h1234);
    wdt_timeout = 1;
    port_pins = 8'h81;
    clr = 3'h7;
    tick(1);
    wdt_timeout = 0;
    clr = 3'h0;
    tick(3);
    check({in_stop, core_reset}, 2'b00);
    reset_pin_n = 0;
    tick(4);
    stop_exec = 1;
    tick(1);
    stop_exec = 0;
    tick(15);
    check({core_reset, regfile_reset}, 2'b11);
    reset_pin_n = 1;
    wait_run();
    check(n <= 6, 1);
    check({in_stop, watchdog_control_reg}, 4'b0001);
    wake(1, 0, 1, 0);
    wake(1, 1, 1, 1);
    wake(1, 1, 0, 0);
    wake(0, 0, 1, 0);
    conclude();
  end
endmodule
bind reset_stop_recovery reset_stop_recovery_assertions #(.SHORT_RESET_CYCLES(SHORT_RESET_CYCLES))
  i_chk (.mclk(mclk), .nrst(nrst), .reset_pin_n(reset_pin_n), .stop_exec(stop_exec),
  .irq_enable(irq_enable), .wdt_timeout(wdt_timeout), .core_reset(core_reset),
  .regfile_reset(regfile_reset), .in_stop(in_stop), .vec_rd(vec_rd), .vec_addr(vec_addr),
  .vec_data(vec_data), .pc_load(pc_load), .pc(pc), .wdt_irq_req(wdt_irq_req),
  .external_reset_flag(external_reset_flag), .watchdog_timeout_flag(watchdog_timeout_flag));
`default_nettype wire
